// ### charge_seq_pkg.sv
// Constants, register map and state encoding of the charge state sequencer
// Behaviour
// - Short suspend returns to short stage when temperature is fine or thermistor off
// - Low-battery timer freezes in short and precondition suspend, then resumes
// - Every temperature-suspend state blinks the status pin with one-second period
// - Precondition current is the 4-bit precharge percentage, 5 to 20 percent
// - Precondition entered after voltage above short threshold for 16 ms
// - Fast charge entered after voltage above low threshold for 16 ms in precondition
// - Low-battery timer accumulates over short and precondition, 2 hours, then fault
// - Battery OV, input UV/OV or unmasked regulator fault forces fault state from short, precondition, fast or full
// - Precondition suspend only from precondition; no charging; returns on recovery
// - Current below termination over 750 ms with termination off goes to full
// - Fast charge uses constant current below target, constant voltage at it
// - Regulation voltage is an 11-bit field across two registers
// - Fast current is a 7-bit percentage of resistor full scale
// - Termination current is a 4-bit field beside the precharge field
// - Fast entry clears low timer; fast timer 30 min to 16 h, expiry faults
// - Voltage below low threshold for 16 ms in fast charge returns to precondition
// - Fast suspend only from fast; fast timer freezes and resumes on return
// - Full returns to fast on current above termination or low voltage for 16 ms
// - Charge full clears both timers and releases the status pin
// - Full suspend only from full, keeps fast timer at zero, returns to full
// - Termination supplies no current, recharges when voltage drops below threshold
// - Status pin driven low in precondition and fast charge
// - Current below termination over 750 ms with termination on goes to termination
package charge_seq_pkg;
	// Register offsets
	localparam logic [7:0] VOLT_A_OFF = 8'h11;
	localparam logic [7:0] VOLT_B_OFF = 8'h12;
	localparam logic [7:0] FAST_PCT_OFF = 8'h18;
	localparam logic [7:0] PRE_TERM_OFF = 8'h19;
	localparam logic [7:0] TIMER_CFG_OFF = 8'h1B;
	localparam logic [7:0] STATUS_OFF = 8'h1C;
	// Field positions
	localparam int PRE_LSB = 4;
	localparam int TERM_LSB = 0;
	localparam int VOLT_B_BITS = 3;
	// Reset values
	localparam logic [7:0] VOLT_A_RST = 8'h00;
	localparam logic [7:0] VOLT_B_RST = 8'h00;
	localparam logic [6:0] FAST_PCT_RST = 7'h64;
	localparam logic [3:0] PRE_CODE_RST = 4'h5;
	localparam logic [3:0] TERM_CODE_RST = 4'h2;
	localparam logic [4:0] FC_CODE_RST = 5'h0F;
	// Precharge percent is base plus code
	localparam logic [4:0] PRE_PCT_BASE = 5'h05;
	// Timing
	localparam int CLK_HZ = 50_000_000;
	localparam int QUAL_MS = 16;
	localparam int TERM_QUAL_MS = 750;
	localparam int HALF_SEC_MS = 500;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int QUAL_CYC = QUAL_MS * CYC_PER_MS;
	localparam int TERM_QUAL_CYC = TERM_QUAL_MS * CYC_PER_MS + 1;
	localparam int HALF_SEC_CYC = HALF_SEC_MS * CYC_PER_MS;
	localparam int LOWBAT_LIMIT_S = 2 * 3600;
	localparam int FC_STEP_S = 30 * 60;
	// One-hot states
	typedef enum logic [9:0] {
		SHORT_ST = 10'h001,
		SHORT_SUSP_ST = 10'h002,
		PRE_ST = 10'h004,
		PRE_SUSP_ST = 10'h008,
		FAST_ST = 10'h010,
		FAST_SUSP_ST = 10'h020,
		FULL_ST = 10'h040,
		FULL_SUSP_ST = 10'h080,
		TERM_ST = 10'h100,
		FAULT_ST = 10'h200
	} chg_state_t;
endpackage : charge_seq_pkg

// ### qual_delay.sv
// Qualification delay: condition must hold continuously for a cycle count
`timescale 1ns/1ps
`default_nettype none
module qual_delay #(
	parameter int LIMIT = 800_000,
	parameter int CNT_W = 32
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic en_i,
	input wire logic cond_i,
	output logic met_o
);
	logic [CNT_W-1:0] cnt_r;
	wire logic hold = en_i & cond_i;
	wire logic at_limit = (cnt_r == CNT_W'(LIMIT));

	// Restart from zero on any lapse, saturate at the limit
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r <= '0;
		end else if (!hold) begin
			cnt_r <= '0;
		end else if (!at_limit) begin
			cnt_r <= cnt_r + CNT_W'(1);
		end
	end

	assign met_o = hold & at_limit;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	a_lapse_restarts: assert property (!hold |=> cnt_r == '0)
		else $error("qualifier did not restart");
	a_met_needs_hold: assert property (met_o |-> $past(hold))
		else $error("qualifier met without history");
endmodule : qual_delay
`default_nettype wire

// ### charge_seq.sv
// Charge state sequencer: states, safety timers, status pin and settings registers
`timescale 1ns/1ps
`default_nettype none
module charge_seq import charge_seq_pkg::*; #(
	parameter int QUAL_CYCLES = QUAL_CYC,
	parameter int TERM_QUAL_CYCLES = TERM_QUAL_CYC,
	parameter int HALF_SEC_CYCLES = HALF_SEC_CYC
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	output logic [7:0] reg_rdata_o,
	input wire logic vbat_above_short_i,
	input wire logic vbat_above_low_i,
	input wire logic vbat_below_good_i,
	input wire logic vbat_at_reg_i,
	input wire logic vbat_below_recharge_i,
	input wire logic constant_charge_current_below_term_i,
	input wire logic temp_ok_i,
	input wire logic thermistor_input_en_i,
	input wire logic term_enable_i,
	input wire logic vbat_ov_i,
	input wire logic vin_fault_i,
	input wire logic aux_regulator_fault_i,
	input wire logic charge_regulator_fault_mask_i,
	output logic [9:0] state_o,
	output logic charge_on_o,
	output logic cv_mode_o,
	output logic [6:0] current_pct_o,
	output logic [3:0] termination_current_o,
	output logic [10:0] charge_voltage_setting_o,
	output logic charge_status_out_o,
	output logic charge_status_out_oe_n_o,
	output logic [12:0] lowbat_timer_o,
	output logic [15:0] fast_timer_o
);
	chg_state_t state_r, state_nxt;
	logic [7:0] volt_a_r, volt_b_r, pre_term_r;
	logic [6:0] fast_pct_r;
	logic [4:0] fc_code_r;
	logic [24:0] div_r;
	logic blink_r;
	logic [12:0] low_t_r;
	logic [15:0] fast_t_r;
	logic cv_r;

	// Precondition current: fast percent scaled by precharge percent
	function automatic logic [6:0] pre_pct(input logic [6:0] fast, input logic [3:0] code);
		logic [11:0] prod;
		prod = 12'(fast) * 12'(PRE_PCT_BASE + 5'(code));
		return 7'(prod / 12'd100);
	endfunction : pre_pct

	// Register writes from the serial port
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			volt_a_r <= VOLT_A_RST;
			volt_b_r <= VOLT_B_RST;
			fast_pct_r <= FAST_PCT_RST;
			pre_term_r <= {PRE_CODE_RST, TERM_CODE_RST};
			fc_code_r <= FC_CODE_RST;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				VOLT_A_OFF: volt_a_r <= reg_wdata_i;
				VOLT_B_OFF: volt_b_r <= {5'h00, reg_wdata_i[VOLT_B_BITS-1:0]};
				FAST_PCT_OFF: fast_pct_r <= reg_wdata_i[6:0];
				PRE_TERM_OFF: pre_term_r <= reg_wdata_i;
				TIMER_CFG_OFF: fc_code_r <= reg_wdata_i[4:0];
				default: ;
			endcase
		end
	end

	// Read mux; status register shows the state index
	// One-hot state to its index; a loop avoids a non-constant $clog2
	function automatic logic [3:0] state_index(input logic [9:0] s);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 0; i < 10; i++) begin
			if (s[i]) idx = 4'(i);
		end
		return idx;
	endfunction : state_index
	wire logic [3:0] state_idx = state_index(state_r);
	always_comb begin
		unique case (reg_addr_i)
			VOLT_A_OFF: reg_rdata_o = volt_a_r;
			VOLT_B_OFF: reg_rdata_o = volt_b_r;
			FAST_PCT_OFF: reg_rdata_o = {1'b0, fast_pct_r};
			PRE_TERM_OFF: reg_rdata_o = pre_term_r;
			TIMER_CFG_OFF: reg_rdata_o = {3'h0, fc_code_r};
			STATUS_OFF: reg_rdata_o = {4'h0, state_idx};
			default: reg_rdata_o = 8'h00;
		endcase
	end

	// Field decode
	wire logic [3:0] pre_code = pre_term_r[PRE_LSB+3:PRE_LSB];
	wire logic [3:0] term_code = pre_term_r[TERM_LSB+3:TERM_LSB];
	wire logic [15:0] fc_limit = 16'((int'(fc_code_r) + 1) * FC_STEP_S);

	// Half-second divider; a second elapses every other half tick
	wire logic half_tick = (div_r == 25'(HALF_SEC_CYCLES - 1));
	wire logic sec_tick = half_tick & blink_r;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_r <= '0;
			blink_r <= 1'b0;
		end else begin
			div_r <= half_tick ? '0 : div_r + 25'(1);
			blink_r <= blink_r ^ half_tick;
		end
	end

	// State decode
	wire logic in_short = (state_r == SHORT_ST);
	wire logic in_pre = (state_r == PRE_ST);
	wire logic in_fast = (state_r == FAST_ST);
	wire logic in_full = (state_r == FULL_ST);
	wire logic in_susp = state_r inside {SHORT_SUSP_ST, PRE_SUSP_ST, FAST_SUSP_ST, FULL_SUSP_ST};

	// Condition qualifiers
	logic q_short, q_low_up, q_low_dn, q_term, q_cur_up, q_good_dn;
	qual_delay #(.LIMIT(QUAL_CYCLES)) u_q_short (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.en_i(in_short), .cond_i(vbat_above_short_i), .met_o(q_short));
	qual_delay #(.LIMIT(QUAL_CYCLES)) u_q_low_up (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.en_i(in_pre), .cond_i(vbat_above_low_i), .met_o(q_low_up));
	qual_delay #(.LIMIT(QUAL_CYCLES)) u_q_low_dn (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.en_i(in_fast), .cond_i(!vbat_above_low_i), .met_o(q_low_dn));
	qual_delay #(.LIMIT(TERM_QUAL_CYCLES)) u_q_term (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.en_i(in_fast), .cond_i(constant_charge_current_below_term_i), .met_o(q_term));
	qual_delay #(.LIMIT(QUAL_CYCLES)) u_q_cur_up (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.en_i(in_full), .cond_i(!constant_charge_current_below_term_i), .met_o(q_cur_up));
	qual_delay #(.LIMIT(QUAL_CYCLES)) u_q_good_dn (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.en_i(in_full), .cond_i(vbat_below_good_i), .met_o(q_good_dn));

	// Hazards and timer expiry
	wire logic temp_bad = thermistor_input_en_i & !temp_ok_i;
	wire logic hw_fault = vbat_ov_i | vin_fault_i
		| (aux_regulator_fault_i & !charge_regulator_fault_mask_i);
	wire logic low_exp = (low_t_r >= 13'(LOWBAT_LIMIT_S));
	wire logic fast_exp = (fast_t_r >= fc_limit);

	// Next state: faults first, then temperature, then qualified moves
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SHORT_ST: begin
				if (hw_fault || low_exp) state_nxt = FAULT_ST;
				else if (temp_bad) state_nxt = SHORT_SUSP_ST;
				else if (q_short) state_nxt = PRE_ST;
			end
			SHORT_SUSP_ST: if (!temp_bad) state_nxt = SHORT_ST;
			PRE_ST: begin
				if (hw_fault || low_exp) state_nxt = FAULT_ST;
				else if (temp_bad) state_nxt = PRE_SUSP_ST;
				else if (q_low_up) state_nxt = FAST_ST;
			end
			PRE_SUSP_ST: if (!temp_bad) state_nxt = PRE_ST;
			FAST_ST: begin
				if (hw_fault || fast_exp) state_nxt = FAULT_ST;
				else if (temp_bad) state_nxt = FAST_SUSP_ST;
				else if (q_low_dn) state_nxt = PRE_ST;
				else if (q_term) state_nxt = term_enable_i ? TERM_ST : FULL_ST;
			end
			FAST_SUSP_ST: if (!temp_bad) state_nxt = FAST_ST;
			FULL_ST: begin
				if (hw_fault) state_nxt = FAULT_ST;
				else if (temp_bad) state_nxt = FULL_SUSP_ST;
				else if (q_cur_up || q_good_dn) state_nxt = FAST_ST;
			end
			FULL_SUSP_ST: if (!temp_bad) state_nxt = FULL_ST;
			TERM_ST: if (vbat_below_recharge_i) state_nxt = FAST_ST;
			FAULT_ST: state_nxt = FAULT_ST;
			default: state_nxt = FAULT_ST;
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) state_r <= SHORT_ST;
		else state_r <= state_nxt;
	end

	// Low-battery timer: counts in short and precondition, frozen in their
	// suspends and in fault, cleared on the very edge that enters fast charge
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			low_t_r <= '0;
		end else if (state_nxt inside {FAST_ST, FAST_SUSP_ST, FULL_ST, FULL_SUSP_ST, TERM_ST}) begin
			low_t_r <= '0;
		end else if (in_short || in_pre) begin // Suspends hold the count
			if (sec_tick && !low_exp) low_t_r <= low_t_r + 13'(1);
		end
	end

	// Fast timer: runs in fast charge, frozen in its suspend and in fault,
	// cleared on the edge that leaves for any other state so a return from
	// full starts a fresh window
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fast_t_r <= '0;
		end else if (!(state_nxt inside {FAST_ST, FAST_SUSP_ST, FAULT_ST})) begin
			fast_t_r <= '0;
		end else if (in_fast) begin // Suspend holds the count
			if (sec_tick && !fast_exp) fast_t_r <= fast_t_r + 16'(1);
		end
	end

	// Regulation mode: constant voltage only while at target in fast charge or full
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) cv_r <= 1'b0;
		else cv_r <= (in_fast || in_full) && vbat_at_reg_i;
	end

	// Outputs; suspends, termination and fault supply no current
	assign state_o = state_r;
	assign charge_on_o = in_short || in_pre || in_fast || in_full;
	assign cv_mode_o = cv_r;
	assign current_pct_o = in_pre ? pre_pct(fast_pct_r, pre_code) : fast_pct_r;
	assign termination_current_o = term_code;
	assign charge_voltage_setting_o = {volt_b_r[VOLT_B_BITS-1:0], volt_a_r};
	assign lowbat_timer_o = low_t_r;
	assign fast_timer_o = fast_t_r;

	// Open-drain status pin: low while charging, blinking on suspend or fault,
	// released when full or terminated. Blink relies on blink_r never resetting
	// mid-state, so the phase may be anywhere on suspend entry.
	assign charge_status_out_o = 1'b0;
	assign charge_status_out_oe_n_o = (in_short || in_pre || in_fast) ? 1'b0
		: (in_susp || state_r == FAULT_ST) ? blink_r
		: 1'b1;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_pre_entry;
		!in_pre ##1 in_pre;
	endsequence
	sequence s_no_fast_yet;
		!in_fast [*8];
	endsequence

	a_pre_min_time: assert property (s_pre_entry |-> s_no_fast_yet)
		else $error("left precondition too early");
	a_fault_routing: assert property ((in_pre || in_fast || in_full) && hw_fault
		|=> state_r == FAULT_ST)
		else $error("fault not taken");
	a_low_freeze: assert property (state_r inside {SHORT_SUSP_ST, PRE_SUSP_ST}
		|=> $stable(low_t_r))
		else $error("low timer moved in suspend");
	a_fast_freeze: assert property (state_r == FAST_SUSP_ST |=> $stable(fast_t_r))
		else $error("fast timer moved in suspend");
	a_full_clears: assert property (in_full |=> low_t_r == '0 && fast_t_r == '0)
		else $error("timers not cleared in full");
	a_full_release: assert property (in_full |-> charge_status_out_oe_n_o)
		else $error("status pin driven in full");
	a_busy_low: assert property (in_pre || in_fast |-> !charge_status_out_oe_n_o)
		else $error("status pin not low while charging");
	a_susp_blink: assert property (in_susp && half_tick && state_nxt == state_r
		|=> charge_status_out_oe_n_o != $past(charge_status_out_oe_n_o))
		else $error("status pin not blinking");
	a_term_exit: assert property (state_r == TERM_ST && vbat_below_recharge_i
		|=> in_fast)
		else $error("recharge not started");
	a_short_resume: assert property (state_r == SHORT_SUSP_ST && !temp_bad
		|=> in_short)
		else $error("short suspend not left");
	a_term_route: assert property (in_fast && q_term && !hw_fault && !fast_exp && !temp_bad
		&& !q_low_dn |=> state_r == (term_enable_i ? TERM_ST : FULL_ST))
		else $error("termination route wrong");
	a_low_expiry: assert property (in_pre && low_exp |=> state_r == FAULT_ST)
		else $error("low timer expiry ignored");
endmodule : charge_seq
`default_nettype wire

// ### battery_model.sv
// Battery pack and power stage stand-in: coarse voltage level to comparator flags
`timescale 1ns/1ps
`default_nettype none
module battery_model (
	input wire logic [1:0] level_i,
	input wire logic cur_low_i,
	input wire logic charge_on_i,
	output logic above_short_o,
	output logic above_low_o,
	output logic below_good_o,
	output logic at_reg_o,
	output logic below_recharge_o,
	output logic below_term_o
);
	// Nested thresholds, so the flags never contradict each other
	assign above_short_o = (level_i >= 2'h1);
	assign above_low_o = (level_i >= 2'h2);
	assign below_good_o = (level_i < 2'h2);
	assign at_reg_o = (level_i == 2'h3);
	assign below_recharge_o = (level_i != 2'h3);
	// No current flows while charging is off, which reads as below termination
	assign below_term_o = cur_low_i | ~charge_on_i;
endmodule : battery_model
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the charge state sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top import charge_seq_pkg::*; ;
	localparam int QC = 8;
	localparam int HC = 4;
	logic clk_i, arst_n_i, reg_wr_i, cur_low, temp_ok_i, thermistor_input_en_i, term_enable_i;
	logic vbat_ov_i, vin_fault_i, aux_regulator_fault_i, charge_regulator_fault_mask_i;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [1:0] level;
	logic vbat_above_short_i, vbat_above_low_i, vbat_below_good_i, vbat_at_reg_i;
	logic vbat_below_recharge_i, constant_charge_current_below_term_i, charge_on_o, cv_mode_o;
	logic charge_status_out_o, charge_status_out_oe_n_o;
	logic [9:0] state_o;
	logic [6:0] current_pct_o;
	logic [3:0] termination_current_o;
	logic [10:0] charge_voltage_setting_o;
	logic [12:0] lowbat_timer_o, t0;
	logic [15:0] fast_timer_o, f0;
	int err_count, comparisons, n;
	// Short counts keep the timers reachable: one second is 2*HC cycles
	charge_seq #(.QUAL_CYCLES(QC), .TERM_QUAL_CYCLES(20), .HALF_SEC_CYCLES(HC)) dut (.clk_i,
		.arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rdata_o, .vbat_above_short_i,
		.vbat_above_low_i, .vbat_below_good_i, .vbat_at_reg_i, .vbat_below_recharge_i,
		.constant_charge_current_below_term_i, .temp_ok_i, .thermistor_input_en_i, .term_enable_i, .vbat_ov_i,
		.vin_fault_i, .aux_regulator_fault_i, .charge_regulator_fault_mask_i, .state_o,
		.charge_on_o, .cv_mode_o, .current_pct_o, .termination_current_o,
		.charge_voltage_setting_o, .charge_status_out_o, .charge_status_out_oe_n_o,
		.lowbat_timer_o, .fast_timer_o);
	battery_model pack (.level_i(level), .cur_low_i(cur_low), .charge_on_i(charge_on_o),
		.above_short_o(vbat_above_short_i), .above_low_o(vbat_above_low_i),
		.below_good_o(vbat_below_good_i), .at_reg_o(vbat_at_reg_i),
		.below_recharge_o(vbat_below_recharge_i), .below_term_o(constant_charge_current_below_term_i));
	// Clock, 20 ns period
	initial begin
		clk_i = 1'h0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_i);
	endtask : cyc
	// Writes are one-cycle strobes launched on a falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'h1;
		cyc(1);
		reg_wr_i = 1'h0;
		cyc(1);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		reg_addr_i = a;
		cyc(1);
		`CHK(reg_rdata_o, e)
	endtask : rdchk
	// Bounded wait for a state, n keeps the cycles spent
	task automatic go(input logic [9:0] s, input int lim);
		n = 0;
		while (state_o !== s && n < lim) begin
			cyc(1);
			n++;
		end
		`CHK(state_o, s)
	endtask : go
	// The blink phase runs free, so count toggles over four half periods
	task automatic blink;
		int t;
		logic p;
		t = 0;
		p = charge_status_out_oe_n_o;
		repeat (4 * HC) begin
			cyc(1);
			t += int'(charge_status_out_oe_n_o !== p);
			p = charge_status_out_oe_n_o;
		end
		`CHK(t, 4)
	endtask : blink
	task automatic do_reset;
		arst_n_i = 1'h0;
		cyc(4);
		arst_n_i = 1'h1;
	endtask : do_reset
	task automatic conclude;
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude
	// Watchdog sized above the two long timer runs
	initial begin
		#(90000 * 20);
		err_count++;
		conclude();
	end
	// Main sequence
	initial begin
		{reg_wr_i, cur_low, term_enable_i, vbat_ov_i, vin_fault_i} = 5'h00;
		{aux_regulator_fault_i, charge_regulator_fault_mask_i} = 2'h0;
		{temp_ok_i, thermistor_input_en_i} = 2'h3;
		{reg_addr_i, reg_wdata_i, level, err_count, comparisons} = '0;
		do_reset();
		rdchk(VOLT_A_OFF, VOLT_A_RST);
		rdchk(FAST_PCT_OFF, 8'h64);
		rdchk(PRE_TERM_OFF, 8'h52);
		rdchk(8'h40, 8'h00);
		wr(VOLT_A_OFF, 8'hA5);
		wr(VOLT_B_OFF, 8'hFE);
		wr(PRE_TERM_OFF, 8'hF3);
		rdchk(VOLT_B_OFF, 8'h06);
		`CHK(charge_voltage_setting_o, 11'h6A5)
		`CHK(termination_current_o, 4'h3)
		wr(FAST_PCT_OFF, 8'hC8);
		`CHK(current_pct_o, 7'h48)
		wr(FAST_PCT_OFF, 8'h64);
		$display("registers done");
		temp_ok_i = 1'h0;
		go(SHORT_SUSP_ST, 2);
		blink();
		thermistor_input_en_i = 1'h0;
		go(SHORT_ST, 2);
		{temp_ok_i, thermistor_input_en_i} = 2'h3;
		level = 2'h1;
		cyc(QC - 1);
		level = 2'h0;
		cyc(1);
		level = 2'h1;
		go(PRE_ST, 40);
		`CHK(n >= QC, 1'h1)
		rdchk(STATUS_OFF, 8'h02);
		`CHK(current_pct_o, 7'h14)
		`CHK(charge_status_out_oe_n_o, 1'h0)
		`CHK(charge_status_out_o, 1'h0)
		cyc(40);
		temp_ok_i = 1'h0;
		go(PRE_SUSP_ST, 2);
		`CHK(charge_on_o, 1'h0)
		t0 = lowbat_timer_o;
		blink();
		cyc(24);
		`CHK(lowbat_timer_o, t0)
		thermistor_input_en_i = 1'h0;
		go(PRE_ST, 2);
		{temp_ok_i, thermistor_input_en_i} = 2'h3;
		cyc(40);
		`CHK(lowbat_timer_o > t0, 1'h1)
		$display("short and precondition done");
		level = 2'h2;
		go(FAST_ST, 40);
		`CHK(n >= QC, 1'h1)
		`CHK(lowbat_timer_o, 13'h0000)
		`CHK(charge_status_out_oe_n_o, 1'h0)
		level = 2'h3;
		cyc(2);
		`CHK(cv_mode_o, 1'h1)
		level = 2'h2;
		cyc(2);
		`CHK(cv_mode_o, 1'h0)
		cyc(40);
		temp_ok_i = 1'h0;
		go(FAST_SUSP_ST, 2);
		f0 = fast_timer_o;
		cyc(24);
		`CHK(fast_timer_o, f0)
		temp_ok_i = 1'h1;
		go(FAST_ST, 2);
		level = 2'h1;
		go(PRE_ST, 40);
		level = 2'h3;
		go(FAST_ST, 40);
		cur_low = 1'h1;
		go(FULL_ST, 60);
		`CHK(n >= 20, 1'h1)
		`CHK({charge_status_out_oe_n_o, fast_timer_o, lowbat_timer_o}, 30'h20000000)
		temp_ok_i = 1'h0;
		go(FULL_SUSP_ST, 2);
		cyc(16);
		`CHK(fast_timer_o, 16'h0000)
		temp_ok_i = 1'h1;
		go(FULL_ST, 2);
		cur_low = 1'h0;
		go(FAST_ST, 40);
		{cur_low, term_enable_i} = 2'h3;
		go(TERM_ST, 60);
		`CHK(charge_on_o, 1'h0)
		level = 2'h2;
		go(FAST_ST, 2);
		{cur_low, charge_regulator_fault_mask_i, aux_regulator_fault_i} = 3'h3;
		cyc(3);
		`CHK(state_o, FAST_ST)
		charge_regulator_fault_mask_i = 1'h0;
		go(FAULT_ST, 2);
		aux_regulator_fault_i = 1'h0;
		cyc(3);
		`CHK(state_o, FAULT_ST)
		$display("fast, full and termination done");
		// Each remaining fault source from a fresh start
		for (int i = 0; i < 2; i++) begin
			do_reset();
			{vbat_ov_i, vin_fault_i} = (i == 0) ? 2'h2 : 2'h1;
			go(FAULT_ST, 2);
			{vbat_ov_i, vin_fault_i} = 2'h0;
		end
		do_reset();
		wr(TIMER_CFG_OFF, 8'hE0);
		rdchk(TIMER_CFG_OFF, 8'h00);
		go(PRE_ST, 40);
		go(FAST_ST, 40);
		go(FAULT_ST, 15000);
		`CHK(n > 14000, 1'h1)
		do_reset();
		level = 2'h1;
		go(PRE_ST, 40);
		go(FAULT_ST, 58000);
		`CHK(n > 57000, 1'h1)
		$display("safety timers done");
		conclude();
	end
endmodule : tb_top
`default_nettype wire
